// [pld_pkg.sv]
// Shared constants of the macrocell array: sizes, register map, fields, resets, timing
package pld_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int CELL_COUNT     = 8;
    localparam int INPUT_COUNT    = 8;
    localparam int TERMS_PER_CELL = 8;
    localparam int TERM_COUNT     = CELL_COUNT * TERMS_PER_CELL;
    localparam int COLUMN_COUNT   = 4 * INPUT_COUNT;
    localparam int PIN_COUNT      = 2 * INPUT_COUNT + 3;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [11:0] CTRL_OFFSET    = 12'h000;
    localparam logic [11:0] CELL_OFFSET    = 12'h004;
    localparam logic [11:0] STATUS_OFFSET  = 12'h008;
    localparam logic [11:0] SIG_LO_OFFSET  = 12'h010;
    localparam logic [11:0] SIG_HI_OFFSET  = 12'h014;
    localparam logic [11:0] FUSE_OFFSET    = 12'h100;
    localparam logic [11:0] FUSE_PAGE_MASK = 12'hf00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_ALLOW_BIT    = 0;
    localparam int CTRL_EMULATE_BIT  = 1;
    localparam int CTRL_LOW_POWER_BIT = 2;
    localparam int CTRL_SECURE_BIT   = 3;
    localparam int CTRL_ERASE_BIT    = 4;
    localparam int CELL_CONFIG_LSB   = 0;
    localparam int CELL_POLARITY_LSB = 8;
    localparam int STATUS_STANDBY_BIT = 0;
    localparam int STATUS_SECURE_BIT = 1;
    localparam int STATUS_STATE_LSB  = 8;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic        CTRL_BIT_RESET = 1'b0;
    localparam logic [7:0]  CELL_RESET     = 8'h00;
    localparam logic [31:0] SIG_RESET      = 32'h0000_0000;
    localparam logic [31:0] FUSE_RESET     = 32'h0000_0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLOCK_PERIOD_NS     = 4;
    localparam int STANDBY_IDLE_NS     = 50;
    localparam int STANDBY_IDLE_CYCLES = (STANDBY_IDLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage

// [input_sync.sv]
// Two-stage synchroniser for pin inputs
module input_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             reset_in,
    // Pins and synchronised copy
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // input_sync

// [product_term.sv]
// One AND-array product term with unused-term disable
module product_term #(
    parameter int COLUMNS = 32
) (
    // Fuse row and literals
    input  wire logic [COLUMNS-1:0] fuse_in,
    input  wire logic [COLUMNS-1:0] literal_in,
    input  wire logic               disable_unused_in,
    // Result
    output logic                    term_out
);
    wire unused = (fuse_in == '0);

    // Open term reads high, true and complement together read low
    assign term_out = ~(disable_unused_in & unused) & (&(literal_in | ~fuse_in));
endmodule // product_term

// [pld_macrocell_array.sv]
// Macrocell array of a sum-of-products logic device with APB configuration
// What this block does
// - Code 101 makes a cell a dedicated input, output buffer always off.
// - Dedicated inputs feed adjacent pin; edge cells feed shared clock or enable pin.
// - Codes 010, 011, 100, 101, 111 select cell modes; others undefined.
// - Polarity bit drives an XOR: 1 active high, 0 active low.
// - Power-up clears every cell flip-flop to low.
// - After power-up registered outputs read high, combinatorial ones follow logic.
// - Test can load any value from the pin into each register.
// - Security bit set refuses array readback and verification.
// - Security bit clears only with full array erase.
// - A 64-bit signature word holds user data.
// - Signature stays readable whatever the security bit.
// - Low-power variant enters standby after 50 ns without input change.
// - Standby holds every output at its previous value.
// - Any input change leaves standby with no added delay.
// - Low-power variant disables unused product terms.
// - Registered mode captures all eight terms on shared clock rising edge.
// - I/O modes use seven terms; first enables buffer; pin fed back.
// - Edge cells steer feedback by register-allow bit: set feeds adjacent pin.
// - Open term is high; true and complement together give low.
//
// Chosen here: the register offsets and the APB slave port.
module pld_macrocell_array
    import pld_pkg::*;
(
    // Clock and reset
    input  wire logic                   clock_in,
    input  wire logic                   reset_in,
    // APB slave
    input  wire logic [11:0]            paddr_in,
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [31:0]            pwdata_in,
    output logic      [31:0]            prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    // Device pins
    input  wire logic [INPUT_COUNT-1:0] input_pin_in,
    input  wire logic                   clock_pin_in,
    input  wire logic                   enable_pin_n_in,
    input  wire logic                   preload_in,
    input  wire logic [CELL_COUNT-1:0]  io_pin_in,
    output logic      [CELL_COUNT-1:0]  io_pin_out,
    output logic      [CELL_COUNT-1:0]  io_pin_oe_out,
    // State
    output logic                        standby_out
);
    // ****************************************************************
    // Configuration storage
    // ****************************************************************
    logic                  register_allow;
    logic                  emulation_select;
    logic                  low_power;
    logic                  security;
    logic [CELL_COUNT-1:0] cell_config_select;
    logic [CELL_COUNT-1:0] cell_polarity_select;
    logic [31:0]           signature_lo;
    logic [31:0]           signature_hi;
    logic [31:0]           fuse_row [0:TERM_COUNT-1];
    logic [CELL_COUNT-1:0] cell_state;
    logic [7:0]            idle_cnt;

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    logic [PIN_COUNT-1:0] pin_sync;
    logic [PIN_COUNT-1:0] pin_prev;

    input_sync #(.WIDTH(PIN_COUNT)) pin_sync_u (
        .clock_in (clock_in),
        .reset_in (reset_in),
        .async_in ({preload_in, enable_pin_n_in, clock_pin_in, input_pin_in, io_pin_in}),
        .sync_out (pin_sync)
    );

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_sync;
        end
    end

    wire [CELL_COUNT-1:0]  io_level   = pin_sync[CELL_COUNT-1:0];
    wire [INPUT_COUNT-1:0] dedicated  = pin_sync[CELL_COUNT +: INPUT_COUNT];
    wire                   clock_pin  = pin_sync[PIN_COUNT-3];
    wire                   enable_n   = pin_sync[PIN_COUNT-2];
    wire                   preload    = pin_sync[PIN_COUNT-1];
    wire                   clock_rise = clock_pin & ~pin_prev[PIN_COUNT-3];
    wire [PIN_COUNT-1:0]   pin_diff   = pin_sync ^ pin_prev;
    wire input_change = (|pin_diff[PIN_COUNT-1:CELL_COUNT])
                      | (|(pin_diff[CELL_COUNT-1:0] & ~io_pin_oe_out));

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    wire [CELL_COUNT-1:0] a_bits  = {CELL_COUNT{register_allow}};
    wire [CELL_COUNT-1:0] e_bits  = {CELL_COUNT{emulation_select}};
    wire [CELL_COUNT-1:0] c_bits  = cell_config_select;
    wire [CELL_COUNT-1:0] reg_mode  = ~a_bits &  e_bits & ~c_bits;
    wire [CELL_COUNT-1:0] cio_reg   = ~a_bits &  e_bits &  c_bits;
    wire [CELL_COUNT-1:0] cout_mode =  a_bits & ~e_bits & ~c_bits;
    wire [CELL_COUNT-1:0] din_mode  =  a_bits & ~e_bits &  c_bits;
    wire [CELL_COUNT-1:0] cio_mode  =  a_bits &  e_bits &  c_bits;
    wire [CELL_COUNT-1:0] io_mode   = cio_reg | cio_mode;
    wire [CELL_COUNT-1:0] undef_mode = ~(reg_mode | io_mode | cout_mode | din_mode);

    // ****************************************************************
    // Feedback and AND array
    // ****************************************************************
    logic [CELL_COUNT-1:0]   feedback;
    logic [COLUMN_COUNT-1:0] literal;
    logic [TERM_COUNT-1:0]   term;
    logic [CELL_COUNT-1:0]   xor_val;
    logic [CELL_COUNT-1:0]   comb_oe;
    logic [CELL_COUNT-1:0]   next_state;
    logic [CELL_COUNT-1:0]   next_out;
    logic [CELL_COUNT-1:0]   next_oe;

    genvar g;
    generate
        for (g = 0; g < 2 * INPUT_COUNT; g++) begin : g_col
            wire x = (g < INPUT_COUNT) ? dedicated[g % INPUT_COUNT] : feedback[g % CELL_COUNT];
            assign literal[2*g]   = x;
            assign literal[2*g+1] = ~x;
        end
        for (g = 0; g < TERM_COUNT; g++) begin : g_term
            product_term #(.COLUMNS(COLUMN_COUNT)) term_u (
                .fuse_in           (fuse_row[g]),
                .literal_in        (literal),
                .disable_unused_in (low_power),
                .term_out          (term[g])
            );
        end
        for (g = 0; g < CELL_COUNT; g++) begin : g_cell
            wire oe_term = term[g*TERMS_PER_CELL];
            wire or7     = |term[g*TERMS_PER_CELL+1 +: TERMS_PER_CELL-1];
            wire sum     = io_mode[g] ? or7 : (or7 | oe_term);
            wire adjacent = (g == 0) ? enable_n :
                            (g == CELL_COUNT-1) ? clock_pin : io_level[g+1];
            wire edge_cell = (g == 0) || (g == CELL_COUNT-1);
            wire use_adjacent = edge_cell ? register_allow : din_mode[g];
            assign feedback[g] = use_adjacent ? adjacent :
                                 reg_mode[g] ? cell_state[g] : io_level[g];
            assign xor_val[g] = sum ^ ~cell_polarity_select[g];
            assign comb_oe[g] = reg_mode[g] ? ~enable_n :
                                io_mode[g] ? oe_term : cout_mode[g];
            assign next_state[g] = (preload & reg_mode[g]) ? ~io_level[g] :
                                   (clock_rise & reg_mode[g]) ? ~xor_val[g] :
                                   cell_state[g];
            assign next_out[g] = reg_mode[g] ? ~cell_state[g] : xor_val[g];
            assign next_oe[g]  = (preload & reg_mode[g]) ? 1'b0 : comb_oe[g];
        end
    endgenerate

    // ****************************************************************
    // Macrocell registers and outputs
    // ****************************************************************
    wire hold = standby_out & ~input_change;

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            cell_state <= '0;
        end else begin
            cell_state <= next_state;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            io_pin_out    <= '0;
            io_pin_oe_out <= '0;
        end else if (!hold) begin
            io_pin_out    <= next_out;
            io_pin_oe_out <= next_oe;
        end
    end

    // ****************************************************************
    // Standby
    // ****************************************************************
    wire idle_done = (idle_cnt == 8'(STANDBY_IDLE_CYCLES - 1));

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            idle_cnt    <= '0;
            standby_out <= 1'b0;
        end else if (!low_power || input_change) begin
            idle_cnt    <= '0;
            standby_out <= 1'b0;
        end else if (idle_done) begin
            standby_out <= 1'b1;
        end else begin
            idle_cnt    <= idle_cnt + 8'h01;
        end
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire access_setup = psel_in & penable_in & ~pready_out;
    wire commit       = psel_in & penable_in & pready_out;
    wire word_ok      = (paddr_in[1:0] == 2'h0);
    wire ctrl_hit     = (paddr_in == CTRL_OFFSET);
    wire cell_hit     = (paddr_in == CELL_OFFSET);
    wire status_hit   = (paddr_in == STATUS_OFFSET);
    wire sig_lo_hit   = (paddr_in == SIG_LO_OFFSET);
    wire sig_hi_hit   = (paddr_in == SIG_HI_OFFSET);
    wire fuse_hit     = ((paddr_in & FUSE_PAGE_MASK) == FUSE_OFFSET) & word_ok;
    wire mapped       = ctrl_hit | cell_hit | status_hit | sig_lo_hit | sig_hi_hit | fuse_hit;
    wire [5:0] fuse_index = paddr_in[7:2];
    wire bus_error    = ~mapped | (fuse_hit & security)
                      | (cell_hit & pwrite_in & security);
    wire ctrl_wr      = commit & pwrite_in & ctrl_hit;
    wire erase_cmd    = ctrl_wr & pwdata_in[CTRL_ERASE_BIT];
    wire cfg_wr       = ctrl_wr & ~security & ~pwdata_in[CTRL_ERASE_BIT];
    wire cell_wr      = commit & pwrite_in & cell_hit & ~security;
    wire fuse_wr      = commit & pwrite_in & fuse_hit & ~security;
    wire [31:0] ctrl_word = {27'h0, 1'b0, security, low_power, emulation_select, register_allow};
    wire [31:0] cell_word = {16'h0, cell_polarity_select, cell_config_select};
    wire [31:0] status_word = {16'h0, cell_state, 6'h00, security, standby_out};
    wire [31:0] rd_data = ctrl_hit   ? ctrl_word :
                          cell_hit   ? cell_word :
                          status_hit ? status_word :
                          sig_lo_hit ? signature_lo :
                          sig_hi_hit ? signature_hi :
                          (fuse_hit & ~security) ? fuse_row[fuse_index] : 32'h0;

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end else begin
            pready_out  <= access_setup;
            pslverr_out <= access_setup & bus_error;
            prdata_out  <= (access_setup & ~pwrite_in) ? rd_data : 32'h0;
        end
    end

    // ****************************************************************
    // Configuration writes
    // ****************************************************************
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            register_allow   <= CTRL_BIT_RESET;
            emulation_select <= CTRL_BIT_RESET;
            low_power        <= CTRL_BIT_RESET;
            security         <= CTRL_BIT_RESET;
        end else if (erase_cmd) begin
            register_allow   <= CTRL_BIT_RESET;
            emulation_select <= CTRL_BIT_RESET;
            low_power        <= CTRL_BIT_RESET;
            security         <= CTRL_BIT_RESET;
        end else if (cfg_wr) begin
            register_allow   <= pwdata_in[CTRL_ALLOW_BIT];
            emulation_select <= pwdata_in[CTRL_EMULATE_BIT];
            low_power        <= pwdata_in[CTRL_LOW_POWER_BIT];
            security         <= pwdata_in[CTRL_SECURE_BIT];
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            cell_config_select   <= CELL_RESET;
            cell_polarity_select <= CELL_RESET;
        end else if (erase_cmd) begin
            cell_config_select   <= CELL_RESET;
            cell_polarity_select <= CELL_RESET;
        end else if (cell_wr) begin
            cell_config_select   <= pwdata_in[CELL_CONFIG_LSB +: CELL_COUNT];
            cell_polarity_select <= pwdata_in[CELL_POLARITY_LSB +: CELL_COUNT];
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            signature_lo <= SIG_RESET;
            signature_hi <= SIG_RESET;
        end else begin
            if (commit & pwrite_in & sig_lo_hit) signature_lo <= pwdata_in;
            if (commit & pwrite_in & sig_hi_hit) signature_hi <= pwdata_in;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            for (int r = 0; r < TERM_COUNT; r++) fuse_row[r] <= FUSE_RESET;
        end else if (erase_cmd) begin
            for (int r = 0; r < TERM_COUNT; r++) fuse_row[r] <= FUSE_RESET;
        end else if (fuse_wr) begin
            fuse_row[fuse_index] <= pwdata_in;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    input_buffer_off_a: assert property (1 |=> (($past(din_mode) & io_pin_oe_out) == 8'h00))
        else $error("dedicated input cell drives its pin");
    undefined_off_a: assert property (!hold |=> (($past(undef_mode) & io_pin_oe_out) == 8'h00))
        else $error("undefined cell code drives its pin");
    polarity_out_a: assert property (!hold |=> ((($past(xor_val) ^ io_pin_out) & $past(cout_mode)) == 8'h00))
        else $error("combinatorial output ignores polarity");
    registered_out_a: assert property (!hold |=> ((($past(cell_state) ^ ~io_pin_out) & $past(reg_mode)) == 8'h00))
        else $error("registered output not inverse of flip-flop");
    secure_read_a: assert property (access_setup && !pwrite_in && fuse_hit && security |=> pready_out && pslverr_out && prdata_out == 32'h0)
        else $error("secured array readback not refused");
    secure_clear_a: assert property ($fell(security) |-> $past(erase_cmd))
        else $error("security bit cleared without erase");
    signature_read_a: assert property (access_setup && !pwrite_in && sig_lo_hit |=> prdata_out == $past(signature_lo) && !pslverr_out)
        else $error("signature not readable");
    standby_entry_a: assert property ($rose(standby_out) |-> $past(idle_cnt) == 8'(STANDBY_IDLE_CYCLES - 1) && $past(low_power))
        else $error("standby entered before idle time");
    standby_hold_a: assert property (hold |=> $stable(io_pin_out) && $stable(io_pin_oe_out))
        else $error("output changed in standby");
    standby_wake_a: assert property (input_change |=> !standby_out)
        else $error("standby not left on input change");
    clock_capture_a: assert property (clock_rise && !preload |=> (((cell_state ^ ~$past(xor_val)) & $past(reg_mode)) == 8'h00))
        else $error("register missed clock edge");
    preload_load_a: assert property (preload |=> (((cell_state ^ ~$past(io_level)) & $past(reg_mode)) == 8'h00) && ((io_pin_oe_out & $past(reg_mode)) == 8'h00))
        else $error("preload did not load from pin");

endmodule // pld_macrocell_array

// [board_model.sv]
// Board-side model: resolves the I/O pin levels between device and board
module board_model (
    // Device side
    input  wire logic [7:0] pin_drive_in,
    input  wire logic [7:0] pin_oe_in,
    // Board stimulus
    input  wire logic       board_en_in,
    input  wire logic [7:0] board_val_in,
    // Resolved level
    output logic      [7:0] pin_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board drives only while the device buffers are off; pull-up otherwise
    assign pin_level_out = (pin_oe_in & pin_drive_in)
                         | (~pin_oe_in & (board_en_in ? board_val_in : 8'hff));
endmodule // board_model

// [pld_macrocell_array_tb.sv]
// Self-checking testbench of the macrocell array
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module pld_macrocell_array_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pld_pkg::*;
    logic        clock_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic        pready, pslverr, clock_pin = 0, en_n = 0, preload = 0, standby, drv = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [63:0] sig;
    logic [7:0]  inp = 0, io_in, io_out, io_oe, dval = 0, p;
    int          num_errors = 0, n_tests = 0;
    always #2 clock_in = ~clock_in;
    pld_macrocell_array i_dut (.clock_in(clock_in), .reset_in(reset_in), .paddr_in(paddr),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .input_pin_in(inp), .clock_pin_in(clock_pin), .enable_pin_n_in(en_n),
        .preload_in(preload), .io_pin_in(io_in), .io_pin_out(io_out),
        .io_pin_oe_out(io_oe), .standby_out(standby));
    board_model i_board (.pin_drive_in(io_out), .pin_oe_in(io_oe), .board_en_in(drv),
        .board_val_in(dval), .pin_level_out(io_in));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        do begin
            @(posedge clock_in);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        e = pslverr;
        if (k >= 20) num_errors++;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clock_in);
    endtask
    function automatic logic [7:0] pol_exp(input logic [7:0] pol, input logic sum);
        return sum ? pol : ~pol;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(73));
        cyc(3); reset_in <= 1'b0; cyc(1);
        sig = {$urandom, $urandom}; p = 8'($urandom);
        apb(1, SIG_LO_OFFSET, sig[31:0]); apb(1, SIG_HI_OFFSET, sig[63:32]);
        apb(0, 12'h0fc, 0); `CHK("unmapped err", 1'b1, e)
        $display("test bus done");
        apb(1, CTRL_OFFSET, 32'h1); apb(1, CELL_OFFSET, {16'h0, p, 8'h00}); cyc(6);
        `CHK("comb out", pol_exp(p, 1'b1), io_out)
        `CHK("comb oe", 8'hff, io_oe)
        apb(1, CELL_OFFSET, {16'h0, p, 8'hff}); cyc(6);
        `CHK("input oe", 8'h00, io_oe)
        $display("test combinatorial done");
        apb(1, CTRL_OFFSET, 32'h2); apb(1, CELL_OFFSET, {16'h0, p, 8'h00}); cyc(6);
        `CHK("reg power-up", 8'hff, io_out)
        en_n <= 1'b1; cyc(6); `CHK("reg oe off", 8'h00, io_oe)
        en_n <= 1'b0; clock_pin <= 1'b1; cyc(6);
        `CHK("reg capture", pol_exp(p, 1'b1), io_out)
        clock_pin <= 1'b0; dval <= 8'($urandom); drv <= 1'b1; preload <= 1'b1; cyc(6);
        `CHK("preload oe", 8'h00, io_oe)
        preload <= 1'b0; drv <= 1'b0; cyc(6);
        `CHK("preload value", dval, io_out)
        $display("test registered done");
        apb(1, CTRL_OFFSET, 32'ha); apb(0, FUSE_OFFSET, 0); `CHK("fuse secured", 1'b1, e)
        `CHK("fuse secured data", 32'h0, rd)
        apb(0, SIG_LO_OFFSET, 0); `CHK("sig lo", sig[31:0], rd)
        apb(0, SIG_HI_OFFSET, 0); `CHK("sig hi", sig[63:32], rd)
        apb(1, CTRL_OFFSET, 32'h2); apb(0, STATUS_OFFSET, 0);
        `CHK("secure kept", 1'b1, rd[STATUS_SECURE_BIT])
        apb(1, CTRL_OFFSET, 32'h10); apb(0, STATUS_OFFSET, 0);
        `CHK("secure erased", 1'b0, rd[STATUS_SECURE_BIT])
        $display("test security done");
        apb(1, CTRL_OFFSET, 32'h5); apb(1, CELL_OFFSET, {16'h0, p, 8'h00});
        cyc(STANDBY_IDLE_CYCLES + 8);
        `CHK("standby on", 1'b1, standby)
        `CHK("unused terms", pol_exp(p, 1'b0), io_out)
        apb(1, CELL_OFFSET, {16'h0, ~p, 8'h00}); cyc(4);
        `CHK("standby hold", pol_exp(p, 1'b0), io_out)
        `CHK("standby kept", 1'b1, standby)
        inp <= inp ^ 8'h01; cyc(4);
        `CHK("standby off", 1'b0, standby)
        $display("test standby done");
        // Cell 0 enable term reads input 0; its first OR term holds true and complement
        apb(1, FUSE_OFFSET, 32'h1); apb(1, FUSE_OFFSET + 12'h004, 32'h3);
        for (int m = 0; m < 2; m++) begin
            apb(1, CELL_OFFSET, {16'h0, p, 8'hff}); apb(1, CTRL_OFFSET, m ? 32'h6 : 32'h7);
            inp <= 8'h00; cyc(6);
            `CHK("io oe off", 8'h00, io_oe)
            `CHK("io sum", pol_exp(p, 1'b0), io_out)
            inp <= 8'h01; cyc(6);
            `CHK("io oe on", 8'h01, io_oe)
        end
        $display("test io modes done");
        tally_and_finish();
    end
endmodule // pld_macrocell_array_tb
